// >>> shared/pafm_pkg.sv
// Constants for the port alternate-function multiplexer
package pafm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  localparam int FP_W = 40;
  localparam int BP_W = 4;
  localparam int PWM_W = 3;
  localparam int SYNC_W = 64;
  localparam int SEL_N = 6;
  localparam int SEL_E = 0;
  localparam int SEL_H = 3;
  localparam int SEL_J = 5;
  localparam logic [ADDR_W-1:0] OFF_SEL [SEL_N] =
    '{8'h0c, 8'h11, 8'h13, 8'h15, 8'h17, 8'h19};
  localparam logic [ADDR_W-1:0] OFF_LCD_CTRL = 8'h1e;
  localparam logic [DATA_W-1:0] SEL_RST = 8'h00;
  localparam logic [DATA_W-1:0] LCD_CTRL_RST = 8'h00;
  localparam int LCD_INT_SUPPLY_BIT = 4;
  localparam int PE_CAP1 = 0;
  localparam int PE_CAP2 = 2;
  localparam logic [PORT_W-1:0] PE_ALT_OUT_MASK = 8'hfa;
  localparam logic [FP_W-1:0] FP_IN_ONLY_MASK = 40'h00_0000_ffff;
  localparam logic [FP_W-1:0] FP_PORT_H_MASK = 40'h00_00ff_0000;
  localparam logic [FP_W-1:0] FP_OPEN_DRAIN_MASK = 40'hff_0000_0000;
  localparam logic [PORT_W-1:0] PC_FULL_MASK = 8'hff;
  localparam logic [PORT_W-1:0] PC_REDUCED_MASK = 8'h31;
  localparam int PC_CAP3 = 0;
endpackage

// >>> shared/pafm_port_if.sv
// Per-port select, port data and resulting pin drive
`timescale 1ns/1ps
`default_nettype none
interface pafm_port_if #(parameter int W = 8);
  logic [W-1:0] sel;
  logic [W-1:0] dir;
  logic [W-1:0] dout;
  logic [W-1:0] alt;
  logic [W-1:0] oe;
  logic [W-1:0] po;
  modport ctl (output sel, dir, dout, alt, input oe, po);
  modport mux (input sel, dir, dout, alt, output oe, po);
endinterface
`default_nettype wire

// >>> hdl/pafm_port_e_mux.sv
// Port E pin function selection, open-drain only
`timescale 1ns/1ps
`default_nettype none
module pafm_port_e_mux
  import pafm_pkg::*;
(
  // Port side
  pafm_port_if.mux p
);
  genvar n;
  generate
    for (n = 0; n < PORT_W; n++)
    begin : g_pin
      // Alternate output pulls low on a zero, captures stay released
      assign p.oe[n] = p.sel[n] ? (PE_ALT_OUT_MASK[n] & ~p.alt[n])
                              : (p.dir[n] & ~p.dout[n]);
      assign p.po[n] = 1'b0;
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hdl/pafm_lcd_port_mux.sv
// Ports F to J sharing with the LCD frontplanes
`timescale 1ns/1ps
`default_nettype none
module pafm_lcd_port_mux
  import pafm_pkg::*;
#(
  parameter bit REDUCED_PKG = 1'b0
)
(
  // Port side
  pafm_port_if.mux p
);
  genvar n;
  generate
    for (n = 0; n < FP_W; n++)
    begin : g_pin
      localparam bit IN_ONLY = FP_IN_ONLY_MASK[n];
      localparam bit OPEN_DRAIN = FP_OPEN_DRAIN_MASK[n];
      localparam bit DROPPED = REDUCED_PKG && FP_PORT_H_MASK[n];
      wire od_port = OPEN_DRAIN & ~p.sel[n];
      assign p.oe[n] = DROPPED ? 1'b0 :
                       p.sel[n] ? 1'b1 :
                       IN_ONLY ? 1'b0 :
                       OPEN_DRAIN ? ~p.dout[n] : 1'b1;
      assign p.po[n] = (DROPPED | od_port) ? 1'b0 :
                       (p.sel[n] ? p.alt[n] : p.dout[n]);
    end
  endgenerate
endmodule
`default_nettype wire

// >>> hdl/pafm_top.sv
// Pin-sharing logic of ports C to J with register access
`timescale 1ns/1ps
`default_nettype none
module pafm_top
  import pafm_pkg::*;
#(
  parameter bit REDUCED_PKG = 1'b0
)
(
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [pafm_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [pafm_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [pafm_pkg::DATA_W-1:0] reg_rdata_o,
  // Port E pins and port logic
  input wire logic [pafm_pkg::PORT_W-1:0] port_e_pins_i,
  output logic [pafm_pkg::PORT_W-1:0] port_e_pins_o,
  output logic [pafm_pkg::PORT_W-1:0] port_e_pins_oe_o,
  input wire logic [pafm_pkg::PORT_W-1:0] port_e_dir_i,
  input wire logic [pafm_pkg::PORT_W-1:0] port_e_out_i,
  output logic [pafm_pkg::PORT_W-1:0] port_e_in_o,
  // Timer, clock system and PWM
  input wire logic compare_out_one_i,
  input wire logic compare_out_two_i,
  input wire logic refresh_clk_i,
  input wire logic [pafm_pkg::PWM_W-1:0] pulse_channel_outputs_i,
  output logic capture_in_one_o,
  output logic capture_in_two_o,
  output logic capture_in_three_o,
  // Ports F to J pins, port logic and frontplanes
  input wire logic [pafm_pkg::FP_W-1:0] fp_pins_i,
  output logic [pafm_pkg::FP_W-1:0] fp_pins_o,
  output logic [pafm_pkg::FP_W-1:0] fp_pins_oe_o,
  input wire logic [pafm_pkg::FP_W-1:0] fp_port_out_i,
  output logic [pafm_pkg::FP_W-1:0] fp_port_in_o,
  input wire logic [pafm_pkg::FP_W-1:0] lcd_frontplane_drive_i,
  // LCD backplanes and supply
  input wire logic [pafm_pkg::BP_W-1:0] lcd_backplane_drive_i,
  output logic [pafm_pkg::BP_W-1:0] lcd_backplane_outputs_o,
  output logic lcd_internal_gen_en_o,
  // Tone outputs
  input wire logic tone_level_i,
  input wire logic pacifier_level_i,
  output logic tone_output_o,
  output logic tone_output_oe_o,
  output logic pacifier_tone_output_o,
  // Port C
  input wire logic [pafm_pkg::PORT_W-1:0] port_c_pins_i,
  input wire logic [pafm_pkg::PORT_W-1:0] port_c_dir_i,
  input wire logic [pafm_pkg::PORT_W-1:0] port_c_out_i,
  input wire logic port_c_pullup_en_i,
  output logic [pafm_pkg::PORT_W-1:0] port_c_pins_o,
  output logic [pafm_pkg::PORT_W-1:0] port_c_pins_oe_o,
  output logic [pafm_pkg::PORT_W-1:0] port_c_pullup_o,
  output logic [pafm_pkg::PORT_W-1:0] port_c_in_o,
  // Port D
  input wire logic [pafm_pkg::PORT_W-1:0] port_d_pins_i,
  input wire logic [pafm_pkg::PORT_W-1:0] port_d_dir_i,
  input wire logic [pafm_pkg::PORT_W-1:0] port_d_out_i,
  input wire logic [pafm_pkg::PORT_W-1:0] port_d_adc_sel_i,
  output logic [pafm_pkg::PORT_W-1:0] port_d_pins_o,
  output logic [pafm_pkg::PORT_W-1:0] port_d_pins_oe_o,
  output logic [pafm_pkg::PORT_W-1:0] port_d_in_o,
  output logic [pafm_pkg::PORT_W-1:0] port_d_adc_connect_o
);
  import pafm_pkg::*;

  logic [DATA_W-1:0] sel_reg [SEL_N];
  logic [DATA_W-1:0] lcd_ctrl_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [PORT_W-1:0] pe_oe_reg;
  logic [FP_W-1:0] fp_oe_reg;
  logic [FP_W-1:0] fp_po_reg;
  logic [PORT_W-1:0] pc_po_reg;
  logic [PORT_W-1:0] pc_oe_reg;
  logic [PORT_W-1:0] pc_pu_reg;
  logic [PORT_W-1:0] pd_oe_reg;
  logic [PORT_W-1:0] pd_adc_reg;
  logic [BP_W-1:0] bp_reg;
  logic cap1_reg;
  logic cap2_reg;
  logic cap3_reg;
  logic tone_oe_reg;
  logic pac_reg;

  pafm_port_if #(.W(PORT_W)) e_if ();
  pafm_port_if #(.W(FP_W)) fp_if ();

  // Pin synchronisers views
  wire [PORT_W-1:0] pe_sync = sync2_reg[7:0];
  wire [FP_W-1:0] fp_sync = sync2_reg[47:8];
  wire [PORT_W-1:0] pc_sync = sync2_reg[55:48];
  wire [PORT_W-1:0] pd_sync = sync2_reg[63:56];
  wire [SYNC_W-1:0] pins_all =
    {port_d_pins_i, port_c_pins_i, fp_pins_i, port_e_pins_i};

  // Register decode
  wire [SEL_N-1:0] sel_hit;
  wire [SEL_N-1:0] sel_wr;
  wire lcd_hit = reg_addr_i == OFF_LCD_CTRL;
  wire lcd_wr = reg_wr_i & lcd_hit;
  logic [DATA_W-1:0] rd_chain [SEL_N+1];
  wire [DATA_W-1:0] rd_mux =
    rd_chain[SEL_N] | ({DATA_W{lcd_hit}} & lcd_ctrl_reg);
  assign rd_chain[0] = '0;

  genvar i;
  generate
    for (i = 0; i < SEL_N; i++)
    begin : g_sel
      localparam bit GONE = REDUCED_PKG && (i == SEL_H);
      assign sel_hit[i] = (reg_addr_i == OFF_SEL[i]) && !GONE;
      assign sel_wr[i] = reg_wr_i & sel_hit[i];
      assign rd_chain[i+1] =
        rd_chain[i] | ({DATA_W{sel_hit[i]}} & sel_reg[i]);
      always_ff @(posedge sys_clk_i)
      begin
        if (sys_rst_i)
          sel_reg[i] <= SEL_RST;
        else if (ce_i && sel_wr[i])
          sel_reg[i] <= reg_wdata_i;
      end
    end
  endgenerate

  // Port muxes
  assign e_if.sel = sel_reg[SEL_E];
  assign e_if.dir = port_e_dir_i;
  assign e_if.dout = port_e_out_i;
  assign e_if.alt = {pulse_channel_outputs_i, refresh_clk_i,
                     compare_out_two_i, 1'b1, compare_out_one_i, 1'b1};
  assign fp_if.sel = {sel_reg[5], sel_reg[4], sel_reg[3],
                      sel_reg[2], sel_reg[1]};
  assign fp_if.dir = '0;
  assign fp_if.dout = fp_port_out_i;
  assign fp_if.alt = lcd_frontplane_drive_i;

  pafm_port_e_mux u_port_e (
    .p(e_if)
  );

  pafm_lcd_port_mux #(.REDUCED_PKG(REDUCED_PKG)) u_lcd_ports (
    .p(fp_if)
  );

  // Ports C and D
  wire [PORT_W-1:0] pc_keep = REDUCED_PKG ? PC_REDUCED_MASK : PC_FULL_MASK;
  wire [PORT_W-1:0] pc_in_dir = pc_keep & ~port_c_dir_i;
  wire [PORT_W-1:0] pc_pu_next = REDUCED_PKG ? pc_in_dir
    : ({PORT_W{port_c_pullup_en_i}} & pc_in_dir);
  wire [PORT_W-1:0] pd_oe_next = port_d_dir_i & ~port_d_out_i;
  wire [PORT_W-1:0] pd_adc_next =
    REDUCED_PKG ? '0 : port_d_adc_sel_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else if (ce_i)
    begin
      sync1_reg <= pins_all;
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      lcd_ctrl_reg <= LCD_CTRL_RST;
      rdata_reg <= '0;
    end
    else if (ce_i)
    begin
      if (lcd_wr)
        lcd_ctrl_reg <= reg_wdata_i;
      rdata_reg <= reg_rd_i ? rd_mux : '0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      pe_oe_reg <= '0;
      fp_oe_reg <= '0;
      fp_po_reg <= '0;
      cap1_reg <= 1'b0;
      cap2_reg <= 1'b0;
      cap3_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pe_oe_reg <= e_if.oe;
      fp_oe_reg <= fp_if.oe;
      fp_po_reg <= fp_if.po;
      cap1_reg <= sel_reg[SEL_E][PE_CAP1] & pe_sync[PE_CAP1];
      cap2_reg <= sel_reg[SEL_E][PE_CAP2] & pe_sync[PE_CAP2];
      cap3_reg <= pc_sync[PC_CAP3];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      pc_po_reg <= '0;
      pc_oe_reg <= '0;
      pc_pu_reg <= '0;
      pd_oe_reg <= '0;
      pd_adc_reg <= '0;
      bp_reg <= '0;
      tone_oe_reg <= 1'b0;
      pac_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pc_po_reg <= port_c_out_i & pc_keep;
      pc_oe_reg <= port_c_dir_i & pc_keep;
      pc_pu_reg <= pc_pu_next;
      pd_oe_reg <= pd_oe_next;
      pd_adc_reg <= pd_adc_next;
      bp_reg <= lcd_backplane_drive_i;
      tone_oe_reg <= ~tone_level_i;
      pac_reg <= pacifier_level_i;
    end
  end

  // Outputs
  assign reg_rdata_o = rdata_reg;
  assign port_e_pins_o = e_if.po;
  assign port_e_pins_oe_o = pe_oe_reg;
  assign port_e_in_o = pe_sync;
  assign capture_in_one_o = cap1_reg;
  assign capture_in_two_o = cap2_reg;
  assign capture_in_three_o = cap3_reg;
  assign fp_pins_o = fp_po_reg;
  assign fp_pins_oe_o = fp_oe_reg;
  assign fp_port_in_o = fp_sync & FP_IN_ONLY_MASK;
  assign lcd_backplane_outputs_o = bp_reg;
  assign lcd_internal_gen_en_o = lcd_ctrl_reg[LCD_INT_SUPPLY_BIT];
  assign tone_output_o = 1'b0;
  assign tone_output_oe_o = tone_oe_reg;
  assign pacifier_tone_output_o = pac_reg;
  assign port_c_pins_o = pc_po_reg;
  assign port_c_pins_oe_o = pc_oe_reg;
  assign port_c_pullup_o = pc_pu_reg;
  assign port_c_in_o = pc_sync & pc_keep;
  assign port_d_pins_o = '0;
  assign port_d_pins_oe_o = pd_oe_reg;
  assign port_d_in_o = pd_sync;
  assign port_d_adc_connect_o = pd_adc_reg;

  // Checks
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_pe_gpio_drive: assert property (
    ce_i && !sel_reg[SEL_E][1] && port_e_dir_i[1] && !port_e_out_i[1]
    |=> port_e_pins_oe_o[1])
    else $error("port E pin 1 not pulled low in port use");
  chk_pe_capture_in: assert property (
    ce_i && sel_reg[SEL_E][0] |=> capture_in_one_o == $past(pe_sync[0])
    && !port_e_pins_oe_o[0])
    else $error("capture one not routed from port E pin 0");
  chk_pe_refresh_out: assert property (
    ce_i && sel_reg[SEL_E][4]
    |=> port_e_pins_oe_o[4] == !$past(refresh_clk_i))
    else $error("clock system output not on port E pin 4");
  chk_pe_pwm_top: assert property (
    ce_i && sel_reg[SEL_E][7]
    |=> port_e_pins_oe_o[7] == !$past(pulse_channel_outputs_i[2]))
    else $error("PWM channel 3 not on port E pin 7");
  chk_pe_never_high: assert property (
    port_e_pins_o == '0)
    else $error("port E pin driven high");
  chk_backplane_follow: assert property (
    ce_i |=> lcd_backplane_outputs_o == $past(lcd_backplane_drive_i))
    else $error("backplane output does not follow driver");
  chk_fg_input_only: assert property (
    ce_i && sel_reg[1] == '0 && sel_reg[2] == '0
    |=> fp_pins_oe_o[15:0] == '0)
    else $error("port F or G pin driven in port use");
  chk_pj_open_drain: assert property (
    ce_i && sel_reg[SEL_J] == '0 |=> fp_pins_o[39:32] == '0)
    else $error("port J pin driven high");
  chk_fp_route: assert property (
    ce_i && sel_reg[SEL_J][0] |=> fp_pins_oe_o[32]
    && fp_pins_o[32] == $past(lcd_frontplane_drive_i[32]))
    else $error("frontplane 32 not routed");
  chk_tone_drain: assert property (
    ce_i |=> tone_output_oe_o == !$past(tone_level_i) && !tone_output_o)
    else $error("tone output not open-drain");
  chk_supply_select: assert property (
    ce_i && lcd_wr
    |=> lcd_internal_gen_en_o == $past(reg_wdata_i[LCD_INT_SUPPLY_BIT]))
    else $error("internal LCD supply select not taken");
  chk_no_port_h: assert property (
    REDUCED_PKG |-> fp_pins_oe_o[23:16] == '0 && sel_reg[SEL_H] == '0)
    else $error("port H active in reduced package");
  chk_pc_pullups: assert property (
    ce_i && REDUCED_PKG
    |=> port_c_pullup_o == (PC_REDUCED_MASK & ~$past(port_c_dir_i)))
    else $error("port C pull-ups wrong in reduced package");
  chk_pd_drain: assert property (
    ce_i |=> port_d_pins_oe_o == $past(port_d_dir_i & ~port_d_out_i))
    else $error("port D not open-drain");
  chk_reset_clear: assert property (
    $past(sys_rst_i) |-> sel_reg[SEL_E] == SEL_RST)
    else $error("port E control not cleared by reset");
  chk_sel_write: assert property (
    ce_i && sel_wr[SEL_E] |=> sel_reg[SEL_E] == $past(reg_wdata_i))
    else $error("port E control write lost");

  cov_pe_alt: cover property (sel_reg[SEL_E] == 8'hff);
  cov_fp_lcd: cover property (fp_pins_oe_o[32] && sel_reg[SEL_J][0]);
  cov_reg_read: cover property (reg_rd_i && lcd_hit ##1 reg_rdata_o != '0);
endmodule
`default_nettype wire

// >>> tb/pafm_far_side.sv
// Pin-level model of pull-ups and outside drivers around the multiplexer
`timescale 1ns/1ps
`default_nettype none
module pafm_far_side
  import pafm_pkg::*;
(
  // Design pin drive
  input wire logic [pafm_pkg::PORT_W-1:0] e_oe_i,
  input wire logic [pafm_pkg::FP_W-1:0] fp_o_i,
  input wire logic [pafm_pkg::FP_W-1:0] fp_oe_i,
  // Outside levels
  input wire logic [pafm_pkg::PORT_W-1:0] e_ext_i,
  input wire logic [pafm_pkg::FP_W-1:0] fp_ext_i,
  // Resolved pin levels
  output logic [pafm_pkg::PORT_W-1:0] e_pin_o,
  output logic [pafm_pkg::FP_W-1:0] fp_pin_o
);
  // Pull-up, any low driver wins
  assign e_pin_o = e_ext_i & ~e_oe_i;
  // Driven pins show the drive, released pins the outside level
  assign fp_pin_o = (fp_oe_i & fp_o_i) | (~fp_oe_i & fp_ext_i);
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Self-checking bench for the port alternate-function multiplexer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pafm_pkg::*;
  typedef struct {int k; logic [39:0] e; logic [39:0] m;} pafm_note_t;
  logic sys_clk_i, sys_rst_i, ce_i, reg_wr_i, reg_rd_i, rd_d;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, x;
  logic [7:0] port_e_pins_i, port_e_pins_o, port_e_pins_oe_o, port_e_dir_i;
  logic [7:0] port_e_out_i, port_e_in_o, e_ext;
  logic compare_out_one_i, compare_out_two_i, refresh_clk_i;
  logic [2:0] pulse_channel_outputs_i;
  logic capture_in_one_o, capture_in_two_o, capture_in_three_o;
  logic [39:0] fp_pins_i, fp_pins_o, fp_pins_oe_o, fp_port_out_i;
  logic [39:0] fp_port_in_o, lcd_frontplane_drive_i, fp_ext, s;
  logic [3:0] lcd_backplane_drive_i, lcd_backplane_outputs_o;
  logic lcd_internal_gen_en_o, tone_level_i, pacifier_level_i;
  logic tone_output_o, tone_output_oe_o, pacifier_tone_output_o;
  logic port_c_pullup_en_i;
  logic [7:0] port_c_pins_i, port_c_dir_i, port_c_out_i, port_c_pins_o;
  logic [7:0] port_c_pins_oe_o, port_c_pullup_o, port_c_in_o;
  logic [7:0] port_d_pins_i, port_d_dir_i, port_d_out_i, port_d_adc_sel_i;
  logic [7:0] port_d_pins_o, port_d_pins_oe_o, port_d_in_o;
  logic [7:0] port_d_adc_connect_o;
  logic [7:0] r_rd, r_pu, r_pcoe, r_adc, r_pcin;
  logic [39:0] r_fpoe;
  integer seed, fail_count, n_tests, i, j;
  pafm_note_t q[$];
  event snap;
  string nm [12] = '{"rdata", "e_pins", "fp_oe", "fp_o", "capture",
    "lcd_gen", "tone", "backplane", "fp_in", "port_cd", "pin_in",
    "reduced"};

  pafm_top #(.REDUCED_PKG(1'b0)) dut_u (
    .sys_clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .port_e_pins_i, .port_e_pins_o,
    .port_e_pins_oe_o, .port_e_dir_i, .port_e_out_i, .port_e_in_o,
    .compare_out_one_i, .compare_out_two_i, .refresh_clk_i,
    .pulse_channel_outputs_i, .capture_in_one_o, .capture_in_two_o,
    .capture_in_three_o, .fp_pins_i, .fp_pins_o, .fp_pins_oe_o,
    .fp_port_out_i, .fp_port_in_o, .lcd_frontplane_drive_i,
    .lcd_backplane_drive_i, .lcd_backplane_outputs_o,
    .lcd_internal_gen_en_o, .tone_level_i, .pacifier_level_i,
    .tone_output_o, .tone_output_oe_o, .pacifier_tone_output_o,
    .port_c_pins_i, .port_c_dir_i, .port_c_out_i, .port_c_pullup_en_i,
    .port_c_pins_o, .port_c_pins_oe_o, .port_c_pullup_o, .port_c_in_o,
    .port_d_pins_i, .port_d_dir_i, .port_d_out_i, .port_d_adc_sel_i,
    .port_d_pins_o, .port_d_pins_oe_o, .port_d_in_o, .port_d_adc_connect_o
  );
  pafm_far_side far_u (.e_oe_i(port_e_pins_oe_o), .fp_o_i(fp_pins_o),
    .fp_oe_i(fp_pins_oe_o), .e_ext_i(e_ext), .fp_ext_i(fp_ext),
    .e_pin_o(port_e_pins_i), .fp_pin_o(fp_pins_i));
  // Reduced package copy on the same stimulus
  pafm_top #(.REDUCED_PKG(1'b1)) dut_rp_u (
    .sys_clk_i, .sys_rst_i, .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o(r_rd), .port_e_pins_i, .port_e_pins_o(),
    .port_e_pins_oe_o(), .port_e_dir_i, .port_e_out_i, .port_e_in_o(),
    .compare_out_one_i, .compare_out_two_i, .refresh_clk_i,
    .pulse_channel_outputs_i, .capture_in_one_o(), .capture_in_two_o(),
    .capture_in_three_o(), .fp_pins_i, .fp_pins_o(), .fp_pins_oe_o(r_fpoe),
    .fp_port_out_i, .fp_port_in_o(), .lcd_frontplane_drive_i,
    .lcd_backplane_drive_i, .lcd_backplane_outputs_o(),
    .lcd_internal_gen_en_o(), .tone_level_i, .pacifier_level_i,
    .tone_output_o(), .tone_output_oe_o(), .pacifier_tone_output_o(),
    .port_c_pins_i, .port_c_dir_i, .port_c_out_i, .port_c_pullup_en_i,
    .port_c_pins_o(), .port_c_pins_oe_o(r_pcoe), .port_c_pullup_o(r_pu),
    .port_c_in_o(r_pcin), .port_d_pins_i, .port_d_dir_i, .port_d_out_i,
    .port_d_adc_sel_i, .port_d_pins_o(), .port_d_pins_oe_o(),
    .port_d_in_o(), .port_d_adc_connect_o(r_adc)
  );

  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  function automatic logic [39:0] seen(int k);
    case (k)
      0: return 40'({r_rd, reg_rdata_o});
      1: return {24'h0, port_e_pins_o, port_e_pins_oe_o};
      2: return fp_pins_oe_o;
      3: return fp_pins_o;
      4: return {38'h0, capture_in_two_o, capture_in_one_o};
      5: return 40'(lcd_internal_gen_en_o);
      6: return {37'h0, pacifier_tone_output_o, tone_output_oe_o,
        tone_output_o};
      7: return 40'(lcd_backplane_outputs_o);
      8: return fp_port_in_o;
      9: return {port_c_pullup_o, port_c_pins_oe_o, port_c_pins_o,
        port_d_pins_oe_o, port_d_adc_connect_o};
      10: return {port_c_in_o, port_d_in_o, port_e_in_o, port_d_pins_o,
        7'h0, capture_in_three_o};
      default: return {r_pu, r_pcoe, r_adc, r_fpoe[23:16], r_pcin};
    endcase
  endfunction

  task automatic cmp(pafm_note_t n);
    logic [39:0] g;
    g = seen(n.k) & n.m;
    n_tests++;
    if (g !== (n.e & n.m))
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm[n.k], n.e & n.m, g);
    end
  endtask

  // Read data stand in the cycle after the strobe only
  always @(posedge sys_clk_i)
  begin
    rd_d <= reg_rd_i;
    if (rd_d === 1'b1)
      cmp(q.pop_front());
  end
  always @(snap)
    cmp(q.pop_front());

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    q.push_back('{0, 40'({(a == OFF_SEL[SEL_H]) ? 8'h00 : d, d}), 40'hffff});
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
  endtask

  task automatic chk(int k, logic [39:0] e, logic [39:0] m);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    q.push_back('{k, e, m});
    ->snap;
  endtask

  task automatic results();
    if (fail_count == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge sys_clk_i);
    fail_count++;
    results();
  end

  initial
  begin
    seed = 32'hc2a3;
    fail_count = 0;
    n_tests = 0;
    {ce_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, port_e_dir_i} = '0;
    {port_e_out_i, compare_out_one_i, compare_out_two_i, refresh_clk_i} = '0;
    {pulse_channel_outputs_i, fp_port_out_i, lcd_frontplane_drive_i} = '0;
    {lcd_backplane_drive_i, tone_level_i, pacifier_level_i} = '0;
    {port_c_pullup_en_i, port_c_pins_i, port_c_dir_i, port_c_out_i} = '0;
    {port_d_pins_i, port_d_dir_i, port_d_out_i, port_d_adc_sel_i} = '0;
    e_ext = 8'hff;
    fp_ext = '1;
    sys_rst_i = 1'b1;
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    ce_i <= 1'b1;
    for (i = 0; i < SEL_N; i++)
      rd(OFF_SEL[i], SEL_RST);
    rd(OFF_LCD_CTRL, LCD_CTRL_RST);
    chk(1, 40'h0, 40'hffff);
    chk(2, 40'hff_ffff_0000, '1);
    chk(3, 40'h0, 40'hff_ffff_0000);
    chk(9, 40'h0, '1);
    chk(10, 40'h00_00ff_0000, '1);
    chk(11, {PC_REDUCED_MASK, 32'h0}, '1);
    for (i = 0; i < SEL_N; i++)
    begin
      v = 8'($random(seed));
      wr(OFF_SEL[i], v);
      rd(OFF_SEL[i], v);
    end
    wr(8'h0d, 8'h5a);
    rd(8'h0d, 8'h00);
    for (j = 0; j < 8; j++)
    begin
      v = (j == 0) ? 8'hff : 8'($random(seed));
      @(posedge sys_clk_i);
      {port_e_dir_i, port_e_out_i, e_ext} <= 24'($random(seed));
      {compare_out_one_i, compare_out_two_i, refresh_clk_i} <=
        3'($random(seed));
      {pulse_channel_outputs_i, tone_level_i, pacifier_level_i} <=
        5'($random(seed));
      lcd_backplane_drive_i <= 4'($random(seed));
      {port_c_pins_i, port_c_dir_i, port_c_out_i, port_d_adc_sel_i} <=
        $random(seed);
      {port_d_pins_i, port_d_dir_i, port_d_out_i} <= 24'($random(seed));
      port_c_pullup_en_i <= 1'($random(seed));
      wr(OFF_SEL[SEL_E], v);
      repeat (3) @(posedge sys_clk_i);
      x = {pulse_channel_outputs_i, refresh_clk_i, compare_out_two_i,
        1'b0, compare_out_one_i, 1'b0};
      x = (v & PE_ALT_OUT_MASK & ~x) | (~v & port_e_dir_i & ~port_e_out_i);
      chk(1, {24'h0, 8'h00, x}, 40'hffff);
      chk(4, 40'({v[2] & e_ext[2], v[0] & e_ext[0]}), 40'h3);
      chk(6, 40'({pacifier_level_i, ~tone_level_i, 1'b0}), 40'h7);
      chk(7, 40'(lcd_backplane_drive_i), 40'hf);
      chk(9, {{8{port_c_pullup_en_i}} & ~port_c_dir_i, port_c_dir_i,
        port_c_out_i, port_d_dir_i & ~port_d_out_i, port_d_adc_sel_i},
        '1);
      chk(10, {port_c_pins_i, port_d_pins_i, e_ext & ~x, 8'h00, 7'h0,
        port_c_pins_i[PC_CAP3]}, '1);
      chk(11, {PC_REDUCED_MASK & ~port_c_dir_i, PC_REDUCED_MASK &
        port_c_dir_i, 8'h00, 8'h00, PC_REDUCED_MASK & port_c_pins_i},
        '1);
    end
    for (j = 0; j < 8; j++)
    begin
      s = (j == 0) ? '1 : 40'({$random(seed), $random(seed)});
      @(posedge sys_clk_i);
      fp_port_out_i <= 40'({$random(seed), $random(seed)});
      lcd_frontplane_drive_i <= 40'({$random(seed), $random(seed)});
      fp_ext <= 40'({$random(seed), $random(seed)});
      for (i = 1; i < SEL_N; i++)
        wr(OFF_SEL[i], s[8*i-8 +: 8]);
      repeat (3) @(posedge sys_clk_i);
      chk(2, s | (~s & (40'h00_ffff_0000 |
        (FP_OPEN_DRAIN_MASK & ~fp_port_out_i))), '1);
      chk(3, (s & lcd_frontplane_drive_i) | (~s & 40'h00_ffff_0000 &
        fp_port_out_i), s | ~FP_IN_ONLY_MASK);
      chk(8, fp_ext & FP_IN_ONLY_MASK, ~s | ~FP_IN_ONLY_MASK);
    end
    // Clock enable low: write must be ignored
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    wr(OFF_SEL[SEL_E], ~v);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    rd(OFF_SEL[SEL_E], v);
    for (i = 0; i < 2; i++)
    begin
      v = (i == 0) ? 8'h10 : 8'hef;
      wr(OFF_LCD_CTRL, v);
      rd(OFF_LCD_CTRL, v);
      chk(5, 40'(v[LCD_INT_SUPPLY_BIT]), 40'h1);
    end
    results();
  end
endmodule
`default_nettype wire
